/* hw/acac_pkg.sv */
// Shared constants and carriers for the analog clock and converter control.
// Assumes a single 125 MHz core clock and a plain strobe register port.
package acac_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ            = 125;
  localparam int BANDGAP_SETTLE_NS  = 2000;
  localparam int PLL_SETTLE_NS      = 6000;
  localparam int BANDGAP_SETTLE_CYC = (BANDGAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int PLL_SETTLE_CYC     = (PLL_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SAMPLE_BASE_CYC    = 5;
  localparam int CONVERT_CYC        = 12;
  localparam int SAMPLE_MIN_FIELD   = 3;

  // ==========================================================
  // Register offsets (word index times four)
  localparam logic [7:0] OFS_CONFIG_ZERO = 8'h00;
  localparam logic [7:0] OFS_CONFIG_TWO  = 8'h04;
  localparam logic [7:0] OFS_POWER       = 8'h08;
  localparam logic [7:0] OFS_STATUS      = 8'h0c;
  localparam logic [7:0] OFS_CTRL        = 8'h10;
  localparam logic [7:0] OFS_TRIG        = 8'h14;
  localparam logic [7:0] OFS_TRIM        = 8'h18;
  localparam logic [7:0] OFS_CHAN_BASE   = 8'h40;

  // ==========================================================
  // Field positions
  localparam int POS_GAIN      = 0;
  localparam int POS_REF       = 1;
  localparam int POS_CLKDIV    = 4;
  localparam int POS_BG_PD     = 0;
  localparam int POS_RC_PD     = 1;
  localparam int POS_PLL_ON    = 2;
  localparam int POS_CONV_EN   = 3;

  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_CONFIG_ZERO = 32'h0000_0000;
  localparam logic [3:0]  RST_SAMPLE_LEN  = 4'h3;
  localparam logic [3:0]  RST_CLKDIV      = 4'h0;
  localparam logic [7:0]  RST_TRIM        = 8'h80;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_ONE_SINGLE, MODE_REP_SINGLE, MODE_ONE_SCAN, MODE_REP_SCAN
  } acac_mode_t;

  typedef struct packed {
    logic       bandgap_powerdown;
    logic       fast_rc_powerdown;
    logic       pll_power_on;
    logic       conv_enable;
  } acac_power_t;

  typedef struct packed {
    logic       converter_gain_select;
    logic       reference_from_supply;
    logic [3:0] clk_div;
  } acac_analog_t;

endpackage

/* hw/acac_settle.sv */
// Settling timer: ready rises a fixed number of cycles after enable.
// Assumes enable is a registered level on the core clock.
`timescale 1ns/1ns
module acac_settle
  import acac_pkg::*;
#(
  parameter int CYCLES = 250
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Unit control
  input  wire logic enable,
  output logic      ready
);

  // Refuse a count the timer cannot serve
  if (CYCLES < 1) begin : g_bad_cycles
    $error("settle count must be at least one");
  end

  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         rdy_q;
  logic         rdy_d;

  // Count up while enabled; drop at once on disable
  always_comb begin
    cnt_d = cnt_q;
    rdy_d = rdy_q;
    if (!enable) begin
      cnt_d = '0;
      rdy_d = 1'b0;
    end else if (cnt_q == W'(CYCLES - 1)) begin
      rdy_d = 1'b1;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  assign ready = rdy_q & enable; // Falls in the disabling cycle
endmodule

/* hw/acac_trig_count.sv */
// Trigger prescaler: fires once every programmed number of trigger edges.
// Assumes the trigger level is already synchronised to the core clock.
`timescale 1ns/1ns
module acac_trig_count
  import acac_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Trigger
  input  wire logic         trig_sync,
  input  wire logic         arm,
  input  wire logic [W-1:0] preset,
  output logic              fire
);

  logic         prev_q;
  logic         prev_d;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         edge_seen;

  assign edge_seen = trig_sync & ~prev_q;

  // Count rising edges; fire on the preset-th one (0 acts as 1)
  always_comb begin
    prev_d = trig_sync;
    cnt_d  = cnt_q;
    fire   = 1'b0;
    if (!arm) begin
      cnt_d = '0;
    end else if (edge_seen) begin
      if (cnt_q + W'(1) >= preset) begin
        fire  = 1'b1;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
    end
  end
endmodule

/* hw/acac_top.sv */
// Analog clock and converter control: power bits, settling, sequencer.
// Assumes a plain strobe register port and pins from other domains.
`timescale 1ns/1ns
module acac_top
  import acac_pkg::*;
#(
  parameter int SLOTS  = 16,
  parameter int RES_W  = 12,
  parameter int TRIG_W = 8
) (
  // Clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             NRST,
  // Power monitor (comparator output, core supply below 1.1 V)
  input  wire logic             CORE_LOW,
  output logic                  LOGIC_RESET_N,
  // Register port
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [31:0]      REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic [31:0]           REG_RDATA,
  // Timer trigger pins
  input  wire logic [3:0]       TIMER_TRIGGER,
  // Analog controls
  output acac_power_t           POWER_CTRL,
  output acac_analog_t          ANALOG_CTRL,
  output logic [7:0]            CORE_REGULATOR_TRIM,
  output logic                  BANDGAP_READY,
  output logic                  PLL_READY,
  // Converter analog core
  output logic                  CONV_SAMPLE,
  output logic [3:0]            CONV_CHANNEL,
  input  wire logic [RES_W-1:0] CONV_RESULT,
  output logic                  CONV_BUSY
);

  // Refuse sizes the slot map and the read mux cannot serve
  if (SLOTS != 16 || RES_W > 16 || TRIG_W > 23) begin : g_bad
    $error("slot count, result width or preset width out of range");
  end

  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} acac_state_t;

  // ==========================================================
  // Synchronisers for pins
  logic       low_s1_q, low_s2_q;
  logic [3:0] trg_s1_q, trg_s2_q;

  // Two stages; reset-free so pins cross cleanly
  always_ff @(posedge CORE_CLK) begin
    low_s1_q <= CORE_LOW;
    low_s2_q <= low_s1_q;
    trg_s1_q <= TIMER_TRIGGER;
    trg_s2_q <= trg_s1_q;
  end

  // Hold digital logic in reset while the core supply is low
  // Filter itself runs on the slow clock upstream
  assign LOGIC_RESET_N = NRST & ~low_s2_q;

  // ==========================================================
  // Register state
  acac_power_t   pwr_q, pwr_d;
  acac_analog_t  ana_q, ana_d;
  logic [3:0]    samp_q, samp_d;
  logic [7:0]    trim_q, trim_d;
  acac_mode_t    mode_q, mode_d;
  logic [3:0]    last_q, last_d;
  logic [3:0]    tsel_q, tsel_d;
  logic [TRIG_W-1:0] tpre_q, tpre_d;
  logic [3:0]    chan_q [SLOTS];
  logic [3:0]    chan_d [SLOTS];
  logic [RES_W-1:0] res_q [SLOTS];
  logic [RES_W-1:0] res_d [SLOTS];
  logic [31:0]   rdata_q, rdata_d;
  logic          sw_start;

  // Slot region test on address, used by read and write decoding
  function automatic logic is_slot(input logic [7:0] a);
    return a[7:6] == OFS_CHAN_BASE[7:6];
  endfunction

  // ==========================================================
  // Converter sequencer state
  acac_state_t st_q, st_d;
  logic [4:0]  cyc_q, cyc_d;
  logic [3:0]  slot_q, slot_d;
  logic        busy_q, busy_d;
  logic [3:0]  fires;
  logic        start;
  logic        bg_rdy, pll_rdy;

  // Register writes and read mux
  always_comb begin
    pwr_d    = pwr_q;
    ana_d    = ana_q;
    samp_d   = samp_q;
    trim_d   = trim_q;
    mode_d   = mode_q;
    last_d   = last_q;
    tsel_d   = tsel_q;
    tpre_d   = tpre_q;
    rdata_d  = 32'h0000_0000; // Unmapped and reserved read zero
    sw_start = 1'b0;
    for (int i = 0; i < SLOTS; i++) chan_d[i] = chan_q[i];
    if (REG_WR) begin
      if (is_slot(REG_ADDR)) begin
        chan_d[REG_ADDR[5:2]] = REG_WDATA[3:0];
      end else begin
        unique case (REG_ADDR)
          OFS_CONFIG_ZERO: begin
            ana_d.converter_gain_select = REG_WDATA[POS_GAIN];
            ana_d.reference_from_supply = REG_WDATA[POS_REF];
            ana_d.clk_div = REG_WDATA[POS_CLKDIV +: 4];
          end
          OFS_CONFIG_TWO: samp_d = REG_WDATA[3:0];
          OFS_POWER: begin
            pwr_d.bandgap_powerdown = REG_WDATA[POS_BG_PD];
            pwr_d.fast_rc_powerdown = REG_WDATA[POS_RC_PD];
            pwr_d.pll_power_on      = REG_WDATA[POS_PLL_ON];
            pwr_d.conv_enable       = REG_WDATA[POS_CONV_EN];
          end
          OFS_CTRL: begin
            mode_d   = acac_mode_t'(REG_WDATA[1:0]);
            last_d   = REG_WDATA[7:4];
            sw_start = REG_WDATA[8];
          end
          OFS_TRIG: begin
            tsel_d = REG_WDATA[3:0];
            tpre_d = REG_WDATA[8 +: TRIG_W];
          end
          OFS_TRIM: trim_d = REG_WDATA[7:0];
          default: ;
        endcase
      end
    end
    if (REG_RD) begin
      if (is_slot(REG_ADDR)) begin
        rdata_d[3:0]         = chan_q[REG_ADDR[5:2]];
        rdata_d[16 +: RES_W] = res_q[REG_ADDR[5:2]];
      end else begin
        unique case (REG_ADDR)
          OFS_CONFIG_ZERO: rdata_d = {24'h000000, ana_q.clk_div, 2'b00,
                                      ana_q.reference_from_supply,
                                      ana_q.converter_gain_select};
          OFS_CONFIG_TWO:  rdata_d = {28'h0000000, samp_q};
          OFS_POWER:       rdata_d = {28'h0000000, pwr_q.conv_enable,
                                      pwr_q.pll_power_on,
                                      pwr_q.fast_rc_powerdown,
                                      pwr_q.bandgap_powerdown};
          OFS_STATUS:      rdata_d = {24'h000000, slot_q, 1'b0, busy_q,
                                      pll_rdy, bg_rdy};
          OFS_CTRL:        rdata_d = {24'h000000, last_q, 2'b00,
                                      2'(mode_q)};
          OFS_TRIG:        rdata_d = {{(24-TRIG_W){1'b0}}, tpre_q,
                                      4'h0, tsel_q};
          OFS_TRIM:        rdata_d = {24'h000000, trim_q};
          default:         rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Timer prescalers, one per trigger line
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_trig
      acac_trig_count #(.W(TRIG_W)) u_cnt (
        .clk       (CORE_CLK),
        .nrst      (NRST),
        .trig_sync (trg_s2_q[g]),
        .arm       (tsel_q[g] & pwr_q.conv_enable),
        .preset    (tpre_q),
        .fire      (fires[g])
      );
    end
  endgenerate

  // ==========================================================
  // Settling timers
  acac_settle #(.CYCLES(BANDGAP_SETTLE_CYC)) u_bg (
    .clk    (CORE_CLK),
    .nrst   (NRST),
    .enable (~pwr_q.bandgap_powerdown),
    .ready  (bg_rdy)
  );
  acac_settle #(.CYCLES(PLL_SETTLE_CYC)) u_pll (
    .clk    (CORE_CLK),
    .nrst   (NRST),
    .enable (pwr_q.pll_power_on & ~pwr_q.bandgap_powerdown),
    .ready  (pll_rdy)
  );

  assign start = sw_start | (|fires);

  // Sample phase: 5 base cycles stretched by the length field
  // Field 3 gives 8 sample plus 12 convert = 20 clocks per result
  logic [4:0] samp_cyc;
  assign samp_cyc = 5'(SAMPLE_BASE_CYC) + {1'b0, samp_q};

  // Conversion sequencer
  always_comb begin
    st_d   = st_q;
    cyc_d  = cyc_q;
    slot_d = slot_q;
    busy_d = busy_q;
    for (int i = 0; i < SLOTS; i++) res_d[i] = res_q[i];
    unique case (st_q)
      ST_IDLE: begin
        if (start && pwr_q.conv_enable) begin
          st_d   = ST_SAMPLE;
          cyc_d  = 5'h00;
          slot_d = 4'h0;
          busy_d = 1'b1;
        end
      end
      ST_SAMPLE: begin
        if (cyc_q == samp_cyc - 5'h01) begin
          st_d  = ST_CONVERT;
          cyc_d = 5'h00;
        end else begin
          cyc_d = cyc_q + 5'h01;
        end
      end
      ST_CONVERT: begin
        if (cyc_q == 5'(CONVERT_CYC - 1)) begin
          res_d[slot_q] = CONV_RESULT;
          cyc_d = 5'h00;
          st_d  = ST_SAMPLE;
          if ((mode_q == MODE_ONE_SCAN || mode_q == MODE_REP_SCAN)
              && slot_q != last_q) begin
            slot_d = slot_q + 4'h1;
          end else if (mode_q == MODE_REP_SINGLE) begin
            slot_d = 4'h0;
          end else if (mode_q == MODE_REP_SCAN) begin
            slot_d = 4'h0;
          end else begin
            st_d   = ST_IDLE;
            busy_d = 1'b0;
          end
        end else begin
          cyc_d = cyc_q + 5'h01;
        end
      end
    endcase
    if (!pwr_q.conv_enable) begin
      st_d   = ST_IDLE;
      busy_d = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      pwr_q   <= '{bandgap_powerdown: 1'b0, fast_rc_powerdown: 1'b0,
                   pll_power_on: 1'b0, conv_enable: 1'b0};
      ana_q   <= '{converter_gain_select: 1'b0, reference_from_supply: 1'b0,
                   clk_div: RST_CLKDIV};
      samp_q  <= RST_SAMPLE_LEN;
      trim_q  <= RST_TRIM;
      mode_q  <= MODE_ONE_SINGLE;
      last_q  <= 4'h0;
      tsel_q  <= 4'h0;
      tpre_q  <= '0;
      rdata_q <= 32'h0000_0000;
      st_q    <= ST_IDLE;
      cyc_q   <= 5'h00;
      slot_q  <= 4'h0;
      busy_q  <= 1'b0;
      for (int i = 0; i < SLOTS; i++) begin
        chan_q[i] <= 4'h0;
        res_q[i]  <= '0;
      end
    end else begin
      pwr_q   <= pwr_d;
      ana_q   <= ana_d;
      samp_q  <= samp_d;
      trim_q  <= trim_d;
      mode_q  <= mode_d;
      last_q  <= last_d;
      tsel_q  <= tsel_d;
      tpre_q  <= tpre_d;
      rdata_q <= rdata_d;
      st_q    <= st_d;
      cyc_q   <= cyc_d;
      slot_q  <= slot_d;
      busy_q  <= busy_d;
      for (int i = 0; i < SLOTS; i++) begin
        chan_q[i] <= chan_d[i];
        res_q[i]  <= res_d[i];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign REG_RDATA           = rdata_q;
  assign POWER_CTRL          = pwr_q;
  assign ANALOG_CTRL         = ana_q;
  assign CORE_REGULATOR_TRIM = trim_q;   // Regulator runs untouched
  assign BANDGAP_READY       = bg_rdy;
  assign PLL_READY           = pll_rdy;  // Feeds the 24 MHz path
  assign CONV_SAMPLE         = (st_q == ST_SAMPLE);
  assign CONV_CHANNEL        = chan_q[slot_q];
  assign CONV_BUSY           = busy_q;

endmodule

/* verif/acac_assertions.sv */
// Checker on the top ports: settling, reset, register port, converter.
// Assumes it is bound to acac_top from the bench top file.
`timescale 1ns/1ns
module acac_assertions
  import acac_pkg::*;
(
  // Clock and reset
  input wire logic         CORE_CLK,
  input wire logic         NRST,
  // Supply monitor
  input wire logic         CORE_LOW,
  input wire logic         LOGIC_RESET_N,
  // Register port
  input wire logic         REG_RD,
  input wire logic [31:0]  REG_RDATA,
  // Analog controls
  input wire acac_power_t  POWER_CTRL,
  input wire logic [7:0]   CORE_REGULATOR_TRIM,
  input wire logic         BANDGAP_READY,
  input wire logic         PLL_READY,
  // Converter
  input wire logic         CONV_SAMPLE,
  input wire logic         CONV_BUSY
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  // ==========================================================
  // Settling counters, saturating so long runs never wrap
  logic [10:0] bg_q;
  logic [10:0] bg_d;
  logic [10:0] pll_q;
  logic [10:0] pll_d;
  always_comb begin
    bg_d  = (&bg_q) ? bg_q : bg_q + 11'h1;
    pll_d = (&pll_q) ? pll_q : pll_q + 11'h1;
    if (POWER_CTRL.bandgap_powerdown) bg_d = '0;
    if (!POWER_CTRL.pll_power_on || POWER_CTRL.bandgap_powerdown)
      pll_d = '0; // PLL only settles with the bandgap up
  end
  // Registered counts, cleared in reset
  always_ff @(posedge CORE_CLK) begin
    bg_q  <= NRST ? bg_d : '0;
    pll_q <= NRST ? pll_d : '0;
  end

  // ==========================================================
  // Power and settling
  property p_reset_state;
    $rose(NRST) |-> POWER_CTRL == '0 && !PLL_READY
      && CORE_REGULATOR_TRIM == RST_TRIM;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("controls wrong after reset");
  property p_bg_early;
    BANDGAP_READY |-> bg_q >= 11'(BANDGAP_SETTLE_CYC - 1);
  endproperty
  a_bg_early: assert property (p_bg_early)
    else $error("bandgap ready too early");
  property p_bg_late;
    bg_q == 11'(BANDGAP_SETTLE_CYC + 2) |-> BANDGAP_READY;
  endproperty
  a_bg_late: assert property (p_bg_late)
    else $error("bandgap ready too late");
  property p_bg_drop;
    POWER_CTRL.bandgap_powerdown |-> !BANDGAP_READY;
  endproperty
  a_bg_drop: assert property (p_bg_drop)
    else $error("bandgap ready while powered down");
  property p_pll_early;
    PLL_READY |-> POWER_CTRL.pll_power_on
      && pll_q >= 11'(PLL_SETTLE_CYC - 1);
  endproperty
  a_pll_early: assert property (p_pll_early)
    else $error("pll ready too early");
  property p_pll_late;
    pll_q == 11'(PLL_SETTLE_CYC + 2) && BANDGAP_READY |-> PLL_READY;
  endproperty
  a_pll_late: assert property (p_pll_late)
    else $error("pll ready too late");
  property p_por;
    CORE_LOW [*3] |-> !LOGIC_RESET_N;
  endproperty
  a_por: assert property (p_por)
    else $error("logic not held in reset on low core");

  // ==========================================================
  // Register port and converter timing
  property p_rdata_idle;
    !$past(REG_RD) |-> REG_RDATA == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");
  property p_sample_len;
    $rose(CONV_SAMPLE) |-> CONV_SAMPLE [*8];
  endproperty
  a_sample_len: assert property (p_sample_len)
    else $error("sample phase too short");
  property p_convert;
    $fell(CONV_SAMPLE) && POWER_CTRL.conv_enable |->
      ((!CONV_SAMPLE && CONV_BUSY) || !POWER_CTRL.conv_enable) [*8] ##1
      ((!CONV_SAMPLE && CONV_BUSY) || !POWER_CTRL.conv_enable) [*4];
  endproperty
  a_convert: assert property (p_convert)
    else $error("conversion phase too short");
  property p_off_idle;
    !POWER_CTRL.conv_enable [*2] |-> !CONV_SAMPLE;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("sampling while converter off");
endmodule

/* verif/acac_top_tb.sv */
// Self-checking bench for the analog clock and converter control.
// Assumes the checker file is compiled first; it is bound at the foot.
`timescale 1ns/1ns
module acac_top_tb;
  import acac_pkg::*;
  logic         clk, nrst, core_low, wr, rd, rd_p;
  logic         rst_n, bg_rdy, pll_rdy, samp, busy;
  logic [7:0]   addr, trim, v;
  logic [31:0]  wdata, rdata;
  logic [3:0]   trig, chan, run_ch;
  logic [11:0]  res;
  logic [3:0]   ch[4];
  acac_power_t  pwr;
  acac_analog_t ana;
  int           mismatches, checks, done, run, n;
  logic [31:0]  exp_rd[$];
  logic [11:0]  exp_smp[$];

  acac_top dut (
    .CORE_CLK(clk), .NRST(nrst), .CORE_LOW(core_low),
    .LOGIC_RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .TIMER_TRIGGER(trig), .POWER_CTRL(pwr), .ANALOG_CTRL(ana),
    .CORE_REGULATOR_TRIM(trim), .BANDGAP_READY(bg_rdy),
    .PLL_READY(pll_rdy), .CONV_SAMPLE(samp), .CONV_CHANNEL(chan),
    .CONV_RESULT(res), .CONV_BUSY(busy)
  );

  // ==========================================================
  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Compare tasks and the closing task
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp1(string nm, logic e, logic s);
    cmp(nm, {31'h0, e}, {31'h0, s});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Register port; an idle cycle after each strobe keeps drives apart
  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reg_rd(logic [7:0] a, logic [31:0] e);
    exp_rd.push_back(e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // Trigger pulse long enough to pass the two-flop synchroniser
  task automatic pulse(int l);
    trig[l] <= 1'b1;
    repeat (3) @(posedge clk);
    trig[l] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // One conversion run; tl below zero means a software start
  task automatic convert(logic [1:0] m, int cnt, int len, int tl);
    int goal;
    res <= 12'($urandom);
    for (int k = 0; k < cnt; k++)
      exp_smp.push_back({m[1] ? ch[k % 3] : ch[0], 8'(len)});
    goal = done + cnt;
    if (tl < 0) begin
      reg_wr(OFS_CTRL, 32'h120 | 32'(m));
    end else begin
      reg_wr(OFS_TRIG, 32'((tl + 1) << 8) | (32'h1 << tl));
      reg_wr(OFS_CTRL, 32'h20 | 32'(m));
      repeat (tl) pulse(tl);
      cmp1("early start", 1'b0, busy);
      pulse(tl);
    end
    for (int i = 0; i < 900 && done < goal; i++) @(posedge clk);
    // Repeat modes only stop when the converter is switched off
    if (m[0]) reg_wr(OFS_POWER, 32'h4);
    for (int i = 0; i < 40 && busy; i++) @(posedge clk);
    cmp1("busy end", 1'b0, busy);
    if (m[0]) reg_wr(OFS_POWER, 32'hc);
    for (int k = 0; k < (m[0] ? 0 : m[1] ? 3 : 1); k++)
      reg_rd(OFS_CHAN_BASE + 8'(4 * k), {4'h0, res, 12'h0, ch[k]});
  endtask

  // ==========================================================
  // Watcher: reads and sample phases against the oldest note
  always @(posedge clk) rd_p <= rd;
  always @(negedge clk) begin
    if (rd_p) cmp("read data", exp_rd.pop_front(), rdata);
    if (samp) begin
      if (run == 0) run_ch = chan;
      run++;
    end else if (run > 0) begin
      cmp("sample phase", 32'(exp_smp.pop_front()), {20'h0, run_ch, 8'(run)});
      run = 0;
      done++;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h6aeb));
    {nrst, core_low, wr, rd} = '0;
    {addr, wdata, trig} = '0;
    res = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    reg_rd(OFS_CONFIG_ZERO, RST_CONFIG_ZERO);
    reg_rd(OFS_CONFIG_TWO, 32'(RST_SAMPLE_LEN));
    reg_rd(OFS_POWER, 32'h0);
    reg_rd(OFS_TRIM, 32'(RST_TRIM));
    reg_rd(8'h30, 32'h0);
    cmp("clock rate", 32'(RST_CLKDIV), 32'(ana.clk_div));
    for (int i = 0; i < 4; i++) begin
      reg_wr(OFS_CONFIG_ZERO, 32'(i));
      cmp1("gain", i[0], ana.converter_gain_select);
      cmp1("reference", i[1], ana.reference_from_supply);
    end
    v = 8'($urandom);
    reg_wr(OFS_TRIM, {24'h0, v});
    cmp("trim", {24'h0, v}, {24'h0, trim});
    for (int i = 0; i < 400 && !bg_rdy; i++) @(posedge clk);
    cmp1("bandgap ready", 1'b1, bg_rdy);
    reg_wr(OFS_POWER, 32'h4);
    n = 0;
    while (n < 1000 && !pll_rdy) begin
      @(posedge clk);
      n++;
    end
    cmp1("pll settle", 1'b1, n >= PLL_SETTLE_CYC - 3 && n <= PLL_SETTLE_CYC + 2);
    reg_rd(OFS_STATUS, 32'h3);
    // Fast RC goes down with the bandgap, then stays down on its own once the bandgap is back up
    reg_wr(OFS_POWER, 32'h3);
    cmp1("bandgap drop", 1'b0, bg_rdy);
    reg_wr(OFS_POWER, 32'h2);
    cmp1("fast rc off", 1'b1, pwr.fast_rc_powerdown);
    reg_wr(OFS_POWER, 32'h4); // Bandgap already up
    for (int i = 0; i < 1200 && !pll_rdy; i++) @(posedge clk);
    cmp1("pll again", 1'b1, pll_rdy);
    // A start while the converter is off must be ignored
    reg_wr(OFS_CTRL, 32'h100);
    repeat (3) @(posedge clk);
    cmp1("idle when off", 1'b0, busy);
    reg_wr(OFS_POWER, 32'hc);
    for (int s = 0; s < 4; s++) begin
      ch[s] = 4'($urandom);
      reg_wr(OFS_CHAN_BASE + 8'(4 * s), {28'h0, ch[s]});
    end
    for (int m = 0; m < 4; m++)
      convert(2'(m), m[0] ? 5 : m[1] ? 3 : 1, 8, -1);
    reg_wr(OFS_CONFIG_TWO, 32'h5);
    convert(2'h0, 1, 10, -1);
    reg_wr(OFS_CONFIG_TWO, 32'h3);
    for (int l = 0; l < 4; l++)
      convert(2'h0, 1, 8, l);
    core_low <= 1'b1;
    repeat (4) @(posedge clk);
    cmp1("logic reset", 1'b0, rst_n);
    core_low <= 1'b0;
    repeat (4) @(posedge clk);
    cmp1("logic reset", 1'b1, rst_n);
    wrap_up();
  end

  // Watchdog, several times the expected run of about 2300 cycles
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule

bind acac_top acac_assertions u_chk (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .CORE_LOW(CORE_LOW),
  .LOGIC_RESET_N(LOGIC_RESET_N), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .POWER_CTRL(POWER_CTRL),
  .CORE_REGULATOR_TRIM(CORE_REGULATOR_TRIM),
  .BANDGAP_READY(BANDGAP_READY), .PLL_READY(PLL_READY),
  .CONV_SAMPLE(CONV_SAMPLE), .CONV_BUSY(CONV_BUSY)
);
